/* hw/adc_pkg.sv */
// Shared constants and carrier types of the converter control block
package adc_pkg;

	localparam int unsigned RES_W = 8;
	localparam int unsigned NUM_CH = 4;

	// Register offsets
	localparam logic [7:0] OFF_CTRL = 8'h08;
	localparam logic [7:0] OFF_CTRL_ALT = 8'h1f;
	localparam logic [7:0] OFF_PORTCFG = 8'h88;
	localparam logic [7:0] OFF_PORTCFG_ALT = 8'h9f;
	localparam logic [7:0] OFF_RESULT = 8'h09;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h0a;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h0b;

	// Values after reset
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [1:0] PORTCFG_RESET = 2'h0;
	localparam logic [7:0] RESULT_RESET = 8'h00;
	// Pin field resets to all analog, so the enables start all high
	localparam logic [3:0] ANALOG_EN_RESET = 4'hf;

	// Field positions outside the control struct
	localparam int unsigned IRQ_DONE_BIT = 0;
	localparam logic [7:0] SAR_MSB = 8'h80;
	localparam logic [2:0] SAR_TOP_IDX = 3'h7;

	// Conversion clock divider terminal counts (ratio minus one)
	localparam logic [4:0] DIV2_LAST = 5'h01;
	localparam logic [4:0] DIV8_LAST = 5'h07;
	localparam logic [4:0] DIV32_LAST = 5'h1f;

	typedef enum logic [1:0] {
		CLK_DIV2 = 2'b00,
		CLK_DIV8 = 2'b01,
		CLK_DIV32 = 2'b10,
		CLK_RC = 2'b11
	} conv_clock_select_t;

	typedef enum logic [1:0] {
		PINS_ALL_ANALOG = 2'b00,
		PINS_EXT_REF = 2'b01,
		PINS_TWO_ANALOG = 2'b10,
		PINS_ALL_DIGITAL = 2'b11
	} pin_function_select_t;

	// Bit layout of the converter control register, bit 7 first
	typedef struct packed {
		conv_clock_select_t conv_clock_select;
		logic spare_bit;
		logic [1:0] input_channel_select;
		logic go;
		logic conversion_complete_flag;
		logic converter_power_bit;
	} converter_control_reg_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

endpackage : adc_pkg

/* hw/sar_adc_control.sv */
// Register front end, clocking, pin control and sequencing of the 8-bit SAR converter
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps

module sar_adc_control
	import adc_pkg::*;
#(
	parameter bit alt_map = 1'b0
) (
	input wire logic clk,
	input wire logic resetn,
	input wire reg_req_t bus,
	output logic [7:0] rdata,
	input wire logic sleep,
	input wire logic rc_tick,
	input wire logic cmp_above,
	output logic [RES_W-1:0] dac_code,
	output logic [NUM_CH-1:0] chan_sel,
	output logic [NUM_CH-1:0] analog_en,
	output logic ref_ext,
	output logic analog_power,
	output logic irq
);

	typedef struct packed {
		converter_control_reg_t ctrl;
		pin_function_select_t pcfg;
		logic [RES_W-1:0] result;
		logic irq_status;
		logic irq_mask;
		logic start;
		logic [4:0] div_cnt;
		logic tad_tick;
		logic [7:0] rdata;
		logic irq;
		logic [NUM_CH-1:0] chan_sel;
		logic [NUM_CH-1:0] analog_en;
		logic ref_ext;
		logic power;
	} top_state_t;

	localparam logic [7:0] CTRL_ADDR = alt_map ? OFF_CTRL_ALT : OFF_CTRL;
	localparam logic [7:0] PORTCFG_ADDR = alt_map ? OFF_PORTCFG_ALT : OFF_PORTCFG;

	top_state_t s;
	top_state_t next_s;
	logic core_busy;
	logic core_done;
	logic [RES_W-1:0] core_result;
	logic [RES_W-1:0] core_trial;

	sar_core u_core (
		.clk(clk),
		.resetn(resetn),
		.start(s.start),
		// Abort on the same edge as power-off, so busy never outlives the power bit
		.abort(!next_s.ctrl.converter_power_bit),
		.tad_tick(s.tad_tick),
		.cmp_above(cmp_above),
		.busy(core_busy),
		.done(core_done),
		.trial(core_trial),
		.result(core_result)
	);

	always_comb begin
		converter_control_reg_t w;
		converter_control_reg_t rd_ctrl;
		logic [4:0] div_last;
		logic wr_ctrl;
		w = bus.wdata;
		rd_ctrl = s.ctrl;
		wr_ctrl = bus.wr && bus.addr == CTRL_ADDR;
		div_last = DIV2_LAST;
		next_s = s;
		next_s.start = 1'b0;

		// Control register write
		if (wr_ctrl) begin
			next_s.ctrl.conv_clock_select = w.conv_clock_select;
			next_s.ctrl.input_channel_select = w.input_channel_select;
			next_s.ctrl.spare_bit = alt_map ? 1'b0 : w.spare_bit;
			next_s.ctrl.conversion_complete_flag = alt_map ? 1'b0 : w.conversion_complete_flag;
			next_s.ctrl.converter_power_bit = w.converter_power_bit;
			// Clearing go by software does not abort; only power-off does
			if (w.go && w.converter_power_bit && s.ctrl.converter_power_bit
					&& !s.ctrl.go) begin
				next_s.ctrl.go = 1'b1;
				next_s.start = 1'b1;
			end
		end
		if (bus.wr && bus.addr == PORTCFG_ADDR) begin
			next_s.pcfg = pin_function_select_t'(bus.wdata[1:0]);
		end
		if (bus.wr && bus.addr == OFF_IRQ_MASK) begin
			next_s.irq_mask = bus.wdata[IRQ_DONE_BIT];
		end
		if (bus.wr && bus.addr == OFF_IRQ_STATUS && bus.wdata[IRQ_DONE_BIT]) begin
			next_s.irq_status = 1'b0;
		end

		if (!next_s.ctrl.converter_power_bit) begin
			next_s.ctrl.go = 1'b0;
			next_s.start = 1'b0;
		end

		// Completion wins over a same-cycle software clear
		if (core_done) begin
			next_s.ctrl.go = 1'b0;
			next_s.result = core_result;
			next_s.ctrl.conversion_complete_flag = !alt_map;
			next_s.irq_status = 1'b1;
		end

		// Conversion period enable; only runs while a conversion is pending
		unique case (s.ctrl.conv_clock_select)
			CLK_DIV2: div_last = DIV2_LAST;
			CLK_DIV8: div_last = DIV8_LAST;
			CLK_DIV32: div_last = DIV32_LAST;
			CLK_RC: div_last = DIV2_LAST;
		endcase
		next_s.tad_tick = 1'b0;
		if (!s.ctrl.go) begin
			next_s.div_cnt = '0;
		end else if (s.ctrl.conv_clock_select == CLK_RC) begin
			next_s.tad_tick = rc_tick;
		end else if (sleep) begin
			// Main oscillator is stopped in sleep; the conversion holds
			next_s.div_cnt = s.div_cnt;
		end else if (s.div_cnt >= div_last) begin
			next_s.div_cnt = '0;
			next_s.tad_tick = 1'b1;
		end else begin
			next_s.div_cnt = s.div_cnt + 5'h01;
		end

		// Pin and analog side controls
		next_s.power = next_s.ctrl.converter_power_bit;
		next_s.chan_sel = next_s.power
				? (4'b0001 << next_s.ctrl.input_channel_select) : 4'b0000;
		unique case (next_s.pcfg)
			PINS_ALL_ANALOG: next_s.analog_en = 4'b1111;
			PINS_EXT_REF: next_s.analog_en = 4'b1111;
			PINS_TWO_ANALOG: next_s.analog_en = 4'b0011;
			PINS_ALL_DIGITAL: next_s.analog_en = 4'b0000;
		endcase
		next_s.ref_ext = next_s.pcfg == PINS_EXT_REF;

		next_s.irq = next_s.irq_status && next_s.irq_mask;

		// Read data stands only in the cycle after the strobe
		rd_ctrl.go = s.ctrl.go || core_busy;
		next_s.rdata = 8'h00;
		if (bus.rd) begin
			if (bus.addr == CTRL_ADDR) begin
				next_s.rdata = rd_ctrl;
			end else if (bus.addr == PORTCFG_ADDR) begin
				next_s.rdata = {6'h00, s.pcfg};
			end else if (bus.addr == OFF_RESULT) begin
				next_s.rdata = s.result;
			end else if (bus.addr == OFF_IRQ_STATUS) begin
				next_s.rdata = {7'h00, s.irq_status};
			end else if (bus.addr == OFF_IRQ_MASK) begin
				next_s.rdata = {7'h00, s.irq_mask};
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.ctrl <= CTRL_RESET;
			s.pcfg <= pin_function_select_t'(PORTCFG_RESET);
			s.result <= RESULT_RESET;
			s.analog_en <= ANALOG_EN_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign rdata = s.rdata;
	assign dac_code = core_trial;
	assign chan_sel = s.chan_sel;
	assign analog_en = s.analog_en;
	assign ref_ext = s.ref_ext;
	assign analog_power = s.power;
	assign irq = s.irq;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_one_channel: assert property (
		analog_power |-> $onehot(chan_sel) && chan_sel[s.ctrl.input_channel_select])
		else $error("not exactly the selected channel routed");
	a_off_no_route: assert property (
		!analog_power |-> chan_sel == 4'b0000 && !s.ctrl.go && !core_busy)
		else $error("converter active while powered off");
	a_go_starts: assert property (
		bus.wr && bus.addr == CTRL_ADDR && bus.wdata[2] && bus.wdata[0]
		&& s.ctrl.converter_power_bit && !s.ctrl.go
		|=> s.ctrl.go ##1 core_busy)
		else $error("go write did not start a conversion");
	a_go_until_done: assert property (
		s.ctrl.go && !core_done && s.ctrl.converter_power_bit
		&& !(bus.wr && bus.addr == CTRL_ADDR) |=> s.ctrl.go)
		else $error("go dropped before completion");
	a_done_clears: assert property (
		core_done |=> !s.ctrl.go && s.result == $past(core_result))
		else $error("completion did not clear go or load result");
	a_flag_sticky: assert property (
		core_done |=> s.irq_status ##1 (s.irq_status || $past(bus.wr)))
		else $error("done flag not set or lost without a write");
	a_ref_select: assert property (
		ref_ext == (s.pcfg == PINS_EXT_REF))
		else $error("reference select disagrees with pin field");
	a_pin_modes: assert property (
		(s.pcfg == PINS_ALL_DIGITAL |-> analog_en == 4'b0000)
		and (s.pcfg == PINS_ALL_ANALOG |-> analog_en == 4'b1111 && !ref_ext))
		else $error("pin function field not applied");
	a_sleep_hold: assert property (
		sleep && s.ctrl.conv_clock_select != CLK_RC |=> !s.tad_tick)
		else $error("divided clock ticked during sleep");
	a_rc_in_sleep: assert property (
		s.ctrl.go && s.ctrl.conv_clock_select == CLK_RC && rc_tick |=> s.tad_tick)
		else $error("rc clock tick not passed on");
	a_div8_period: assert property (
		s.tad_tick && s.ctrl.conv_clock_select == CLK_DIV8 && !sleep
		&& $stable(s.ctrl) |=> !s.tad_tick [*7])
		else $error("divide by eight ticks too early");
	a_spare_bit: assert property (
		alt_map |-> !s.ctrl.spare_bit && !s.ctrl.conversion_complete_flag)
		else $error("alternate map holds unimplemented bits");
	a_irq_level: assert property (
		irq == (s.irq_status && s.irq_mask))
		else $error("interrupt level disagrees with status and mask");
	a_read_once: assert property (
		!bus.rd |=> rdata == 8'h00)
		else $error("read data outside the answer cycle");

	// Read paths return the value stored before the strobe edge
	a_rdata_result: assert property (
		bus.rd && bus.addr == OFF_RESULT |=> rdata == $past(s.result))
		else $error("result read does not return the stored code");
	a_rdata_status: assert property (
		bus.rd && bus.addr == OFF_IRQ_STATUS |=> rdata == {7'h00, $past(s.irq_status)})
		else $error("status read does not return the flag");
	a_rdata_pcfg: assert property (
		bus.rd && bus.addr == PORTCFG_ADDR |=> rdata == {6'h00, $past(s.pcfg)})
		else $error("pin field read does not return the field");
	a_rdata_busy: assert property (
		bus.rd && bus.addr == CTRL_ADDR && core_busy |=> rdata[2])
		else $error("go reads zero while converting");
	a_two_analog: assert property (
		s.pcfg == PINS_TWO_ANALOG |-> analog_en == 4'b0011 && !ref_ext)
		else $error("two analog pin mode not applied");
	a_ext_ref_pins: assert property (
		s.pcfg == PINS_EXT_REF |-> analog_en == 4'b1111 && ref_ext)
		else $error("external reference pin mode not applied");
	a_power_copy: assert property (
		analog_power == s.ctrl.converter_power_bit)
		else $error("front end power disagrees with power bit");
	a_off_no_start: assert property (
		!s.ctrl.converter_power_bit |=> !s.start)
		else $error("start issued while powered off");
	a_done_flags: assert property (
		core_done |=> s.ctrl.conversion_complete_flag == !alt_map && s.irq_status)
		else $error("completion did not set the done flags");

	// Flags move only for their own events
	a_flag_rise: assert property (
		$rose(s.ctrl.conversion_complete_flag)
		|-> $past(core_done) || ($past(bus.wr) && $past(bus.addr) == CTRL_ADDR))
		else $error("done flag set without completion or write");
	a_flag_fall: assert property (
		$fell(s.ctrl.conversion_complete_flag)
		|-> $past(bus.wr) && $past(bus.addr) == CTRL_ADDR)
		else $error("done flag cleared without a write");
	a_status_fall: assert property (
		$fell(s.irq_status) |-> $past(bus.wr) && $past(bus.addr) == OFF_IRQ_STATUS)
		else $error("status cleared without a write");
	a_go_fall: assert property (
		$fell(s.ctrl.go) |-> $past(core_done) || !s.ctrl.converter_power_bit)
		else $error("go dropped without completion or power-off");
	a_busy_under_go: assert property (
		core_busy |-> s.ctrl.go)
		else $error("core busy while go is clear");
	a_no_idle_tick: assert property (
		!s.ctrl.go |=> !s.tad_tick)
		else $error("conversion period tick while idle");
	a_idle_trial: assert property (
		!core_busy |-> dac_code == 8'h00)
		else $error("trial code driven while idle");

endmodule : sar_adc_control

/* hw/sar_core.sv */
// Successive approximation step engine, one result bit per conversion period
`timescale 1ns/10ps
module sar_core
	import adc_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic start,
	input wire logic abort,
	input wire logic tad_tick,
	input wire logic cmp_above,
	output logic busy,
	output logic done,
	output logic [RES_W-1:0] trial,
	output logic [RES_W-1:0] result
);

	typedef struct packed {
		logic busy;
		logic done;
		logic [2:0] bit_idx;
		logic [RES_W-1:0] trial;
		logic [RES_W-1:0] result;
	} sar_state_t;

	sar_state_t s;
	sar_state_t next_s;

	always_comb begin
		logic [RES_W-1:0] t;
		t = s.trial;
		next_s = s;
		next_s.done = 1'b0;
		if (abort) begin
			next_s.busy = 1'b0;
			next_s.trial = '0;
		end else if (start && !s.busy) begin
			next_s.busy = 1'b1;
			next_s.trial = SAR_MSB;
			next_s.bit_idx = SAR_TOP_IDX;
		end else if (s.busy && tad_tick) begin
			// Keep the trial bit only while the held sample lies above it
			if (!cmp_above) begin
				t[s.bit_idx] = 1'b0;
			end
			if (s.bit_idx == 3'h0) begin
				next_s.busy = 1'b0;
				next_s.done = 1'b1;
				next_s.result = t;
				next_s.trial = '0;
			end else begin
				t[s.bit_idx - 3'h1] = 1'b1;
				next_s.bit_idx = s.bit_idx - 3'h1;
				next_s.trial = t;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign busy = s.busy;
	assign done = s.done;
	assign trial = s.trial;
	assign result = s.result;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_start_msb_trial: assert property (
		start && !busy && !abort |=> busy && trial == SAR_MSB)
		else $error("trial does not open at the top bit");
	a_done_needs_busy: assert property (
		done |-> $past(busy) && !busy && $past(s.bit_idx) == 3'h0)
		else $error("done without a finished bit walk");

endmodule : sar_core

/* tb/testbench.sv */
// Self-checking bench of the converter control block
`timescale 1ns/10ps
module testbench;
	import adc_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	reg_req_t bus = '0;
	logic sleep = 1'b0;
	logic rc_tick = 1'b0;
	logic [7:0] sample = 8'h00;
	logic [7:0] got;
	logic [7:0] rdata;
	logic [7:0] dac_code;
	logic [3:0] chan_sel;
	logic [3:0] analog_en;
	logic ref_ext;
	logic analog_power;
	logic irq;
	logic cmp_above;
	int n_fail = 0;
	int checks_done = 0;
	int rc_cnt = 0;
	logic [7:0] regs [6] = '{OFF_CTRL, OFF_PORTCFG, OFF_RESULT, OFF_IRQ_STATUS, OFF_IRQ_MASK, 8'h55};
	logic [3:0] ae_exp [4] = '{4'hf, 4'hf, 4'h3, 4'h0};
	logic [7:0] smp [3] = '{8'ha5, 8'h00, 8'hff};

	sar_adc_control #(.alt_map(1'b0)) dut_u (
		.clk(clk),
		.resetn(resetn),
		.bus(bus),
		.rdata(rdata),
		.sleep(sleep),
		.rc_tick(rc_tick),
		.cmp_above(cmp_above),
		.dac_code(dac_code),
		.chan_sel(chan_sel),
		.analog_en(analog_en),
		.ref_ext(ref_ext),
		.analog_power(analog_power),
		.irq(irq)
	);

	always #5 clk = ~clk;
	// Ideal comparator against the held level
	assign cmp_above = (sample >= dac_code);
	// Free-running internal oscillator, one tick every five clocks
	always @(posedge clk) begin
		rc_cnt <= (rc_cnt == 4) ? 0 : rc_cnt + 1;
		rc_tick <= (rc_cnt == 4);
	end

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask : rd

	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask : settle

	task automatic conv(input logic [1:0] cs, input logic [7:0] s, input logic [1:0] ch,
			input int nap);
		int i;
		logic [7:0] c;
		c = {cs, 1'b0, ch, 3'h1};
		sample <= s;
		wr(OFF_CTRL, c);
		wr(OFF_CTRL, c | 8'h04);
		// Divided clock stops in sleep; conversion must outlast the nap
		if (nap > 0) begin
			sleep <= 1'b1;
			repeat (nap) @(posedge clk);
			sleep <= 1'b0;
		end
		rd(OFF_CTRL, got);
		chk(got & 8'h04, 8'h04, "go not reading one");
		for (i = 0; i < 400 && got[2]; i++) begin
			rd(OFF_CTRL, got);
		end
		if (got[2]) begin
			n_fail++;
			$display("[FAIL] %0t conversion never finished", $time);
			end_of_test();
		end
		chk(got, c | 8'h02, "control after done");
		rd(OFF_RESULT, got);
		chk(got, s, "result code");
		wr(OFF_CTRL, c);
		rd(OFF_CTRL, got);
		chk(got, c, "done flag clear");
		// Gap longer than two bit periods of the slowest divider
		repeat (70) @(posedge clk);
	endtask : conv

	initial begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		foreach (regs[i]) begin
			rd(regs[i], got);
			chk(got, 8'h00, "reset value");
		end
		$display("test reset values done");

		for (int p = 0; p < 4; p++) begin
			wr(OFF_PORTCFG, 8'(p));
			settle();
			chk({4'h0, analog_en}, {4'h0, ae_exp[p]}, "analog enables");
			chk({7'h0, ref_ext}, {7'h0, p == 1}, "reference select");
			rd(OFF_PORTCFG, got);
			chk(got, 8'(p), "pin field readback");
		end
		wr(OFF_PORTCFG, 8'h00);
		$display("test pin configuration done");

		for (int c = 0; c < 4; c++) begin
			wr(OFF_CTRL, {3'h0, 2'(c), 3'h1});
			settle();
			chk({4'h0, chan_sel}, 8'h01 << c, "channel switch");
			chk({7'h0, analog_power}, 8'h01, "front end power");
		end
		wr(OFF_CTRL, 8'h00);
		settle();
		chk({4'h0, chan_sel}, 8'h00, "switch while off");
		chk({7'h0, analog_power}, 8'h00, "power while off");
		wr(OFF_CTRL, 8'h04);
		rd(OFF_CTRL, got);
		chk(got, 8'h00, "start while off");
		$display("test channels and power done");

		for (int k = 0; k < 3; k++) begin
			conv(2'(k), smp[k], 2'(k), 0);
		end
		conv(2'b00, 8'h5a, 2'b01, 60);
		chk({7'h0, irq}, 8'h00, "masked interrupt");
		rd(OFF_IRQ_STATUS, got);
		chk(got, 8'h01, "status sticky");
		wr(OFF_IRQ_MASK, 8'h01);
		settle();
		chk({7'h0, irq}, 8'h01, "unmasked interrupt");
		wr(OFF_IRQ_STATUS, 8'h01);
		settle();
		chk({7'h0, irq}, 8'h00, "interrupt cleared");
		rd(OFF_IRQ_STATUS, got);
		chk(got, 8'h00, "status cleared");
		wr(OFF_CTRL, 8'h81);
		wr(OFF_CTRL, 8'h85);
		wr(OFF_CTRL, 8'h80);
		rd(OFF_CTRL, got);
		chk(got, 8'h80, "power off aborts");
		repeat (300) @(posedge clk);
		rd(OFF_IRQ_STATUS, got);
		chk(got, 8'h00, "no flag after abort");
		$display("test divided conversions done");

		sleep <= 1'b1;
		conv(2'b11, 8'h3c, 2'b11, 0);
		sleep <= 1'b0;
		$display("test sleep conversion done");

		wr(OFF_CTRL, 8'h20);
		rd(OFF_CTRL, got);
		chk(got, 8'h20, "spare bit storage");
		$display("test spare bit done");
		end_of_test();
	end
endmodule : testbench
